/* File: uefc_top.v */
// Enhanced feature control for one UART channel, with AHB-Lite register slave
// Notes on behaviour
// RULE1: scratch byte is read/write and resets to FF.
// RULE2: two table bits pick table A-D; A-C use next level as thresholds.
// RULE3: RS485 off: transmit interrupt on holding register empty.
// RULE4: RS485 on: RTS drops low after last stop bit leaves shifter.
// RULE5: RS485 on: RTS rises when a byte is loaded, before start bit; rts_n here rises on the same clock edge as the start bit.
// RULE6: RS485 on: transmit interrupt follows shift register empty.
// RULE7: IR polarity bit 0 passes receive input, 1 inverts it.
// RULE8: hysteresis bits act only with table D; code 0 means next level.
// RULE9: hysteresis codes map to fixed character counts around trigger.
// RULE10: auto CTS/DSR stops transmitter on high input, resumes on low.
// RULE11: auto RTS/DTR deasserts high above upper, reasserts below lower level.
// RULE12: software asserts RTS/DTR first; pin is plain output otherwise.
// RULE13: special detect compares received byte with second pause char.
// RULE14: compare mode 01 keeps matching byte out, raises both flags.
// RULE15: gated enhanced bits change only while enhanced enable is 1.
// RULE16: software should leave enhanced enable set in normal use.
// RULE17: software clears flow select bits before a new setting.
// RULE18: transmit select bits 3:2 pick none, first, second or both.
// RULE19: receive select bits 1:0 pick compare mode, 11 depends on tx.
// RULE20: dual modes treat two character registers as one sequence.
// RULE21: read-only level counter shows transmit fill 0 to 64.
// RULE22: write-only trigger; flag when transmit fill falls below it.
// RULE23: RS485 turn-around delays RTS drop by 0-15 bit times.
// RULE24: transmitter disable halts shifter; clearing resumes.
//
// The placing of the registers and the AHB-Lite register port are this design's own decisions.
`timescale 1ns/100ps
`include "uefc_defs.vh"
module uefc_top #(
	parameter BIT_CYCLES = `UEFC_BIT_CYCLES,
	parameter DEPTH = `UEFC_FIFO_DEPTH,
	parameter NEXT_STEP = `UEFC_NEXT_STEP
) (
	input wire mclk,
	input wire rst,
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output reg [31:0] hrdata,
	output reg hreadyout,
	output reg hresp,
	input wire cts_n,
	input wire dsr_n,
	input wire ir_rx,
	input wire rx_valid,
	input wire [7:0] rx_data,
	input wire [6:0] rx_level,
	input wire [7:0] resume_char_first,
	input wire [7:0] resume_char_second,
	input wire [7:0] pause_char_first,
	input wire [7:0] pause_char_second,
	output reg txd,
	output reg rts_n,
	output reg dtr_n,
	output reg ir_rx_data,
	output reg rx_store,
	output reg [7:0] rx_store_data,
	output reg xoff_seen,
	output reg xon_seen,
	output reg [1:0] tx_flow_sel,
	output reg [2:0] rx_cmp_mode,
	output reg tx_irq,
	output reg tx_level_irq,
	output reg rx_trig_irq
);
	localparam ST_IDLE = 3'b001;
	localparam ST_SHIFT = 3'b010;
	localparam ST_TURN = 3'b100;

	reg [7:0] scratch_q, feature_q, enh_q, tx_trig_q, rx_trig_q;
	reg [7:0] modem_ctl_q, modem_wr_q, int_en_q, fifo_ctl_q;
	reg [4:0] sticky_q;
	reg wr_pend_q;
	reg [7:0] wr_addr_q;
	reg [7:0] mem [0:DEPTH-1];
	reg [5:0] wptr_q, rptr_q;
	reg [6:0] count_q;
	reg [2:0] state_q;
	reg [9:0] shift_q;
	reg [3:0] bit_q;
	reg [15:0] timer_q;
	reg [3:0] turn_q;
	reg rts485_q, flow_hold_q;
	reg [1:0] first_hit_q;

	wire acc = hsel & htrans[1] & hready;
	wire rd_acc = acc & ~hwrite;
	wire [7:0] aofs = {haddr[7:2], 2'b00};
	wire [7:0] wb = hwdata[7:0];
	wire enh = enh_q[`UEFC_EF_ENH_EN];
	wire wr_do = wr_pend_q;
	wire push = wr_do && wr_addr_q == `UEFC_OFS_TXDATA && count_q < DEPTH;
	wire bit_end = timer_q == BIT_CYCLES - 1;
	// Flow input is active low on the pin; high means stop
	wire flow_in_n = modem_ctl_q[`UEFC_MC_DTR_SEL] ? dsr_n : cts_n;
	wire cts_stop = enh_q[`UEFC_EF_AUTO_CTS] & flow_in_n; // RULE10
	wire can_send = count_q != 7'd0 && !modem_wr_q[`UEFC_MW_TX_DIS] &&
		!cts_stop; // RULE24
	wire pop = can_send && (state_q == ST_IDLE || state_q == ST_TURN ||
		(state_q == ST_SHIFT && bit_end && bit_q == 4'd9));
	wire rs485 = feature_q[`UEFC_FC_RS485];

	// Hysteresis in characters per code, code F in the top byte
	localparam [127:0] HYST_TAB = {8'd36, 8'd28, 8'd20, 8'd12, 8'd52,
		8'd48, 8'd44, 8'd40, 8'd32, 8'd24, 8'd16, 8'd8, 8'd8, 8'd6,
		8'd4, 8'd0}; // RULE9

	wire table_d = feature_q[`UEFC_FC_TABLE_HI] & feature_q[`UEFC_FC_TABLE_LO];
	wire [7:0] hsel_val = HYST_TAB[feature_q[3:0] * 8 +: 8];
	// Tables A-C and code 0 fall back to the next-level step
	wire [7:0] step = (table_d && hsel_val != 8'd0) ? hsel_val :
		NEXT_STEP[7:0]; // RULE2 RULE8
	wire [8:0] upper = {1'b0, rx_trig_q} + {1'b0, step};
	wire [7:0] lower = (rx_trig_q > step) ? rx_trig_q - step : 8'd0;

	// Transmit and receive flow-select decode
	wire [1:0] txs = enh_q[3:2];
	wire [1:0] rxs = enh_q[1:0];
	reg [2:0] rx_mode_d;
	always @* begin
		case (rxs) // RULE19
		2'b10: rx_mode_d = 3'd1;
		2'b01: rx_mode_d = 3'd2;
		2'b11: rx_mode_d = (txs == 2'b10 || txs == 2'b01) ? 3'd3 : 3'd4;
		default: rx_mode_d = 3'd0;
		endcase
	end

	// Receive compare; mode 4 needs first then second in a row
	wire hit_p1 = rx_data == pause_char_first;
	wire hit_p2 = rx_data == pause_char_second;
	wire hit_r1 = rx_data == resume_char_first;
	wire hit_r2 = rx_data == resume_char_second;
	reg xoff_d, xon_d;
	always @* begin
		case (rx_mode_d)
		3'd1: begin
			xoff_d = hit_p1;
			xon_d = hit_r1;
		end
		3'd2: begin
			xoff_d = hit_p2;
			xon_d = hit_r2;
		end
		3'd3: begin
			xoff_d = hit_p1 | hit_p2;
			xon_d = hit_r1 | hit_r2;
		end
		3'd4: begin
			xoff_d = first_hit_q[1] & hit_p2; // RULE20
			xon_d = first_hit_q[0] & hit_r2;
		end
		default: begin
			xoff_d = 1'b0;
			xon_d = 1'b0;
		end
		endcase
	end
	wire special = enh_q[`UEFC_EF_SPECIAL] & hit_p2; // RULE13
	wire swallow = special && rxs == 2'b01; // RULE14

	// Bus register writes, data phase of the prior address
	always @(posedge mclk) begin
		if (rst) begin
			wr_pend_q <= 1'b0;
			wr_addr_q <= `UEFC_ZERO8;
			scratch_q <= `UEFC_SCRATCH_RST; // RULE1
			feature_q <= `UEFC_ZERO8;
			enh_q <= `UEFC_ZERO8;
			tx_trig_q <= `UEFC_ZERO8;
			rx_trig_q <= `UEFC_ZERO8;
			modem_ctl_q <= `UEFC_ZERO8;
			modem_wr_q <= `UEFC_ZERO8;
			int_en_q <= `UEFC_ZERO8;
			fifo_ctl_q <= `UEFC_ZERO8;
		end else begin
			wr_pend_q <= acc & hwrite;
			wr_addr_q <= aofs;
			if (wr_do) begin
				case (wr_addr_q)
				`UEFC_OFS_SCRATCH: scratch_q <= wb; // RULE1
				`UEFC_OFS_FEATURE: feature_q <= wb;
				`UEFC_OFS_ENH: enh_q <= wb;
				`UEFC_OFS_TXTRIG: tx_trig_q <= wb; // RULE22
				`UEFC_OFS_RXTRIG: rx_trig_q <= wb;
				`UEFC_OFS_MODEM_CTL: modem_ctl_q <= enh ? wb :
					(modem_ctl_q & `UEFC_MASK_MODEM_CTL) |
					(wb & ~`UEFC_MASK_MODEM_CTL); // RULE15
				`UEFC_OFS_MODEM_WR: modem_wr_q <= enh ? wb :
					(modem_wr_q & `UEFC_MASK_MODEM_WR) |
					(wb & ~`UEFC_MASK_MODEM_WR); // RULE15
				`UEFC_OFS_INT_EN: int_en_q <= enh ? wb :
					(int_en_q & `UEFC_MASK_INT_EN) |
					(wb & ~`UEFC_MASK_INT_EN); // RULE15
				`UEFC_OFS_FIFO_CTL: fifo_ctl_q <= enh ? wb :
					(fifo_ctl_q & `UEFC_MASK_FIFO_CTL) |
					(wb & ~`UEFC_MASK_FIFO_CTL); // RULE15
				default: ;
				endcase
			end
		end
	end

	// Read data is prepared during the address phase: zero wait states
	always @(posedge mclk) begin
		if (rst) begin
			hrdata <= 32'h0000_0000;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			if (rd_acc) begin
				case (aofs)
				`UEFC_OFS_SCRATCH: hrdata <= {24'h000000, scratch_q};
				`UEFC_OFS_FEATURE: hrdata <= {24'h000000, feature_q};
				`UEFC_OFS_ENH: hrdata <= {24'h000000, enh_q};
				`UEFC_OFS_TXCOUNT: hrdata <= {25'h0, count_q}; // RULE21
				`UEFC_OFS_MODEM_CTL: hrdata <= {24'h000000, modem_ctl_q};
				`UEFC_OFS_MODEM_WR: hrdata <= {24'h000000, modem_wr_q};
				`UEFC_OFS_INT_EN: hrdata <= {24'h000000, int_en_q};
				`UEFC_OFS_FIFO_CTL: hrdata <= {24'h000000, fifo_ctl_q};
				`UEFC_OFS_RXTRIG: hrdata <= {24'h000000, rx_trig_q};
				`UEFC_OFS_STATUS: hrdata <= {27'h0, sticky_q[4:3],
					rx_trig_irq, tx_level_irq, tx_irq};
				`UEFC_OFS_RXLEVEL: hrdata <= {25'h0, rx_level};
				default: hrdata <= 32'h0000_0000;
				endcase
			end
		end
	end

	// Transmit FIFO storage and level counter
	always @(posedge mclk) begin
		if (push)
			mem[wptr_q] <= wb;
	end
	always @(posedge mclk) begin
		if (rst) begin
			wptr_q <= 6'd0;
			rptr_q <= 6'd0;
			count_q <= 7'd0;
		end else begin
			if (push)
				wptr_q <= wptr_q + 6'd1;
			if (pop)
				rptr_q <= rptr_q + 6'd1;
			if (push && !pop)
				count_q <= count_q + 7'd1; // RULE21
			else if (pop && !push)
				count_q <= count_q - 7'd1;
		end
	end

	// Transmit shifter: start, 8 data LSB first, stop
	always @(posedge mclk) begin
		if (rst) begin
			state_q <= ST_IDLE;
			shift_q <= 10'h3FF;
			bit_q <= 4'd0;
			timer_q <= 16'd0;
			turn_q <= 4'd0;
			txd <= 1'b1;
		end else begin
			case (state_q)
			ST_IDLE: begin
				txd <= 1'b1;
				timer_q <= 16'd0;
				if (pop) begin
					shift_q <= {1'b1, mem[rptr_q], 1'b0};
					bit_q <= 4'd0;
					txd <= 1'b0;
					state_q <= ST_SHIFT;
				end
			end
			ST_SHIFT: begin
				timer_q <= bit_end ? 16'd0 : timer_q + 16'd1;
				if (bit_end) begin
					if (bit_q == 4'd9) begin
						bit_q <= 4'd0;
						if (pop) begin
							// Halt or stop only at a character boundary
							shift_q <= {1'b1, mem[rptr_q], 1'b0};
							txd <= 1'b0;
						end else begin
							txd <= 1'b1;
							turn_q <= modem_wr_q[7:4]; // RULE23
							state_q <= rs485 ? ST_TURN : ST_IDLE;
						end
					end else begin
						bit_q <= bit_q + 4'd1;
						shift_q <= {1'b1, shift_q[9:1]};
						txd <= shift_q[1];
					end
				end
			end
			ST_TURN: begin
				txd <= 1'b1;
				if (pop) begin
					shift_q <= {1'b1, mem[rptr_q], 1'b0};
					bit_q <= 4'd0;
					timer_q <= 16'd0;
					txd <= 1'b0;
					state_q <= ST_SHIFT;
				end else if (turn_q == 4'd0) begin
					state_q <= ST_IDLE; // RULE4
				end else begin
					timer_q <= bit_end ? 16'd0 : timer_q + 16'd1;
					if (bit_end)
						turn_q <= turn_q - 4'd1; // RULE23
				end
			end
			default: state_q <= ST_IDLE;
			endcase
		end
	end

	// RS485 direction and auto RTS/DTR hold
	always @(posedge mclk) begin
		if (rst) begin
			rts485_q <= 1'b0;
			flow_hold_q <= 1'b0;
		end else begin
			if (push)
				rts485_q <= 1'b1; // RULE5
			else if (state_q == ST_TURN && turn_q == 4'd0 && !pop)
				rts485_q <= 1'b0; // RULE4
			if ({2'b00, rx_level} >= upper)
				flow_hold_q <= 1'b1; // RULE11
			else if ({1'b0, rx_level} < lower)
				flow_hold_q <= 1'b0; // RULE11
		end
	end

	wire auto_rts = enh_q[`UEFC_EF_AUTO_RTS];
	wire sel_dtr = modem_ctl_q[`UEFC_MC_DTR_SEL];
	// Software assertion is ANDed in, so auto flow only releases the pin
	wire rts_asrt = modem_ctl_q[`UEFC_MC_RTS] &
		~(auto_rts & ~sel_dtr & flow_hold_q); // RULE12
	wire dtr_asrt = modem_ctl_q[`UEFC_MC_DTR] &
		~(auto_rts & sel_dtr & flow_hold_q); // RULE12
	wire tsr_empty = state_q != ST_SHIFT;

	// Line-side outputs, status and receive handling
	always @(posedge mclk) begin
		if (rst) begin
			rts_n <= 1'b1;
			dtr_n <= 1'b1;
			ir_rx_data <= 1'b0;
			rx_store <= 1'b0;
			rx_store_data <= `UEFC_ZERO8;
			xoff_seen <= 1'b0;
			xon_seen <= 1'b0;
			tx_flow_sel <= 2'b00;
			rx_cmp_mode <= 3'd0;
			tx_irq <= 1'b1;
			tx_level_irq <= 1'b0;
			rx_trig_irq <= 1'b0;
			sticky_q <= 5'd0;
			first_hit_q <= 2'b00;
		end else begin
			// RS485 level on RTS means driver enabled, so pin is high
			rts_n <= rs485 ? rts485_q : ~rts_asrt; // RULE5
			dtr_n <= ~dtr_asrt;
			ir_rx_data <= ir_rx ^ feature_q[`UEFC_FC_IR_INV]; // RULE7
			tx_flow_sel <= txs; // RULE18
			rx_cmp_mode <= rx_mode_d; // RULE19
			if (rs485)
				tx_irq <= count_q == 7'd0 && tsr_empty; // RULE6
			else
				tx_irq <= count_q == 7'd0; // RULE3
			tx_level_irq <= {1'b0, count_q} < tx_trig_q; // RULE22
			rx_trig_irq <= {1'b0, rx_level} >= rx_trig_q; // RULE11
			rx_store <= rx_valid & ~swallow; // RULE14
			rx_store_data <= rx_data;
			xoff_seen <= rx_valid & (xoff_d | swallow); // RULE14
			xon_seen <= rx_valid & xon_d;
			if (rx_valid)
				first_hit_q <= {hit_p1, hit_r1}; // RULE20
			// Read clears sticky flags; a new event in that cycle wins
			if (rd_acc && aofs == `UEFC_OFS_STATUS)
				sticky_q[4:3] <= 2'b00;
			if (rx_valid && (xoff_d || swallow))
				sticky_q[`UEFC_ST_XOFF] <= 1'b1;
			if (rx_valid && special)
				sticky_q[`UEFC_ST_SPECIAL] <= 1'b1; // RULE13
		end
	end
endmodule // uefc_top

/* File: uefc_defs.vh */
// Register map, field positions, reset values and timing for the UART feature block
`ifndef UEFC_DEFS_VH
`define UEFC_DEFS_VH
`define UEFC_OFS_SCRATCH 8'h00
`define UEFC_OFS_FEATURE 8'h04
`define UEFC_OFS_ENH 8'h08
`define UEFC_OFS_TXCOUNT 8'h0C
`define UEFC_OFS_TXTRIG 8'h10
`define UEFC_OFS_TXDATA 8'h14
`define UEFC_OFS_MODEM_CTL 8'h18
`define UEFC_OFS_MODEM_WR 8'h1C
`define UEFC_OFS_INT_EN 8'h20
`define UEFC_OFS_FIFO_CTL 8'h24
`define UEFC_OFS_RXTRIG 8'h28
`define UEFC_OFS_STATUS 8'h2C
`define UEFC_OFS_RXLEVEL 8'h30
`define UEFC_SCRATCH_RST 8'hFF
`define UEFC_ZERO8 8'h00
// feature_control fields
`define UEFC_FC_TABLE_HI 7
`define UEFC_FC_TABLE_LO 6
`define UEFC_FC_RS485 5
`define UEFC_FC_IR_INV 4
// enhanced_feature fields
`define UEFC_EF_AUTO_CTS 7
`define UEFC_EF_AUTO_RTS 6
`define UEFC_EF_SPECIAL 5
`define UEFC_EF_ENH_EN 4
// modem_control fields
`define UEFC_MC_DTR_SEL 2
`define UEFC_MC_RTS 1
`define UEFC_MC_DTR 0
// write-side modem status fields
`define UEFC_MW_TX_DIS 3
// Masks of the gated enhanced bits
`define UEFC_MASK_INT_EN 8'hE0
`define UEFC_MASK_INT_ST 8'h30
`define UEFC_MASK_FIFO_CTL 8'h30
`define UEFC_MASK_MODEM_CTL 8'hEC
`define UEFC_MASK_MODEM_WR 8'hFC
// status fields
`define UEFC_ST_THR_EMPTY 0
`define UEFC_ST_TX_LEVEL 1
`define UEFC_ST_RX_TRIG 2
`define UEFC_ST_XOFF 3
`define UEFC_ST_SPECIAL 4
// Timing
`define UEFC_CLK_HZ 20000000
`define UEFC_BAUD 1250000
`define UEFC_BIT_CYCLES (`UEFC_CLK_HZ / `UEFC_BAUD)
`define UEFC_FRAME_BITS 10
`define UEFC_FIFO_DEPTH 64
`define UEFC_NEXT_STEP 4
`endif

/* File: uefc_chk.sv */
// Port-level assertions for the UART feature block
`timescale 1ns/100ps
module uefc_chk (
	input wire mclk,
	input wire rst,
	input wire [31:0] hrdata,
	input wire hreadyout,
	input wire hresp,
	input wire ir_rx,
	input wire ir_rx_data,
	input wire rx_valid,
	input wire [7:0] rx_data,
	input wire rx_store,
	input wire [7:0] rx_store_data,
	input wire xoff_seen,
	input wire xon_seen,
	input wire [2:0] rx_cmp_mode,
	input wire txd
);
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	bus_ready_a: assert property (hreadyout && !hresp)
		else $error("slave not ready or not okay");
	read_upper_a: assert property (hrdata[31:8] == 24'h0)
		else $error("read data upper bits not zero");
	ir_follow_a: assert property ($changed(ir_rx) |=> $changed(ir_rx_data))
		else $error("infrared input change not passed on");
	store_copy_a: assert property (rx_store |-> $past(rx_valid) &&
		rx_store_data == $past(rx_data))
		else $error("stored byte without matching receive");
	pause_cause_a: assert property (xoff_seen |-> $past(rx_valid))
		else $error("pause hit without a received byte");
	resume_cause_a: assert property (xon_seen |-> $past(rx_valid))
		else $error("resume hit without a received byte");
	mode_range_a: assert property (rx_cmp_mode <= 3'h4)
		else $error("compare mode code out of range");
	start_bit_a: assert property ($fell(txd) |=> !txd)
		else $error("start bit shorter than two cycles");
endmodule // uefc_chk
bind uefc_top uefc_chk u_chk (.mclk(mclk), .rst(rst), .hrdata(hrdata),
	.hreadyout(hreadyout), .hresp(hresp), .ir_rx(ir_rx),
	.ir_rx_data(ir_rx_data), .rx_valid(rx_valid), .rx_data(rx_data),
	.rx_store(rx_store), .rx_store_data(rx_store_data),
	.xoff_seen(xoff_seen), .xon_seen(xon_seen),
	.rx_cmp_mode(rx_cmp_mode), .txd(txd));

/* File: uefc_peer.sv */
// Serial peer: frame capture, flow inputs and receive side
`timescale 1ns/100ps
module uefc_peer #(
	parameter BIT_CYCLES = 2
) (
	input wire mclk,
	input wire txd,
	output reg cts_n,
	output reg dsr_n,
	output reg ir_rx,
	output reg rx_valid,
	output reg [7:0] rx_data,
	output reg [6:0] rx_level
);
	initial begin
		cts_n = 1'b0;
		dsr_n = 1'b0;
		ir_rx = 1'b0;
		rx_valid = 1'b0;
		rx_data = 8'h00;
		rx_level = 7'h00;
	end
	// Samples mid bit, LSB first
	task grab(output [7:0] v);
		integer k;
		begin
			@(negedge txd);
			repeat (BIT_CYCLES / 2) @(posedge mclk);
			for (k = 0; k < 8; k = k + 1) begin
				repeat (BIT_CYCLES) @(posedge mclk);
				v[k] = txd;
			end
			repeat (BIT_CYCLES) @(posedge mclk);
		end
	endtask
	// Released data goes to its inverse so stale bytes never match
	task send(input [7:0] v);
		begin
			rx_data <= v;
			rx_valid <= 1'b1;
			@(posedge mclk);
			rx_valid <= 1'b0;
			rx_data <= ~v;
		end
	endtask
endmodule // uefc_peer

/* File: test_uart_enhanced_feature_control.sv */
// Self-checking bench for the UART feature block
`timescale 1ns/100ps
`include "uefc_defs.vh"
module test_uart_enhanced_feature_control;
	localparam B = 2;
	reg mclk = 1'b0;
	reg rst = 1'b1;
	reg hsel = 1'b0;
	reg hwrite = 1'b0;
	reg [1:0] htrans = 2'h0;
	reg [31:0] haddr = 32'h0;
	reg [31:0] hwdata = 32'h0;
	wire [31:0] hrdata;
	wire hreadyout, txd, rts_n, ir_rx_data, rx_store, xoff_seen, xon_seen;
	wire tx_irq, tx_level_irq, rx_trig_irq, cts_n, dsr_n, ir_rx, rx_valid;
	wire [7:0] rx_data, rx_store_data;
	wire dtr_n;
	reg [7:0] on1 = 8'h11, on2 = 8'h12, off1 = 8'h14, off2 = 8'h13;
	wire [6:0] rx_level;
	wire [1:0] tx_flow_sel;
	wire [2:0] rx_cmp_mode;
	integer fails = 0;
	integer comparisons = 0;
	integer cyc = 0;
	integer i;
	reg [31:0] d;
	reg [7:0] b;
	reg [7:0] ft [0:11] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h05, 8'h05,
		8'hC5, 8'hC5, 8'hC5, 8'hC5, 8'hC1, 8'hC1};
	reg [6:0] lv [0:11] = '{7'h23, 7'h24, 7'h1C, 7'h1B, 7'h24, 7'h1B,
		7'h2F, 7'h30, 7'h10, 7'h0F, 7'h24, 7'h1B};
	reg [0:11] ex = 12'b011010011010;
	uefc_top #(.BIT_CYCLES(B)) u_dut (.mclk(mclk), .rst(rst), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
		.hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(), .cts_n(cts_n), .dsr_n(dsr_n),
		.ir_rx(ir_rx), .rx_valid(rx_valid), .rx_data(rx_data),
		.rx_level(rx_level), .resume_char_first(on1),
		.resume_char_second(on2), .pause_char_first(off1),
		.pause_char_second(off2), .txd(txd), .rts_n(rts_n), .dtr_n(dtr_n),
		.ir_rx_data(ir_rx_data), .rx_store(rx_store),
		.rx_store_data(rx_store_data), .xoff_seen(xoff_seen),
		.xon_seen(xon_seen), .tx_flow_sel(tx_flow_sel),
		.rx_cmp_mode(rx_cmp_mode), .tx_irq(tx_irq),
		.tx_level_irq(tx_level_irq), .rx_trig_irq(rx_trig_irq));
	uefc_peer #(.BIT_CYCLES(B)) p (.mclk(mclk), .txd(txd), .cts_n(cts_n),
		.dsr_n(dsr_n), .ir_rx(ir_rx), .rx_valid(rx_valid),
		.rx_data(rx_data), .rx_level(rx_level));
	initial begin
		forever #25 mclk = ~mclk;
	end
	task conclude;
		begin
			$display("comparisons %0d fails %0d", comparisons, fails);
			if (fails == 0 && comparisons > 0)
				$display("RESULT: PASS");
			else
				$display("RESULT: FAIL");
			$finish;
		end
	endtask
	always @(posedge mclk) begin
		cyc = cyc + 1;
		if (cyc == 20000) begin
			fails = fails + 1;
			conclude;
		end
	end
	task check(input [31:0] seen, input [31:0] exp);
		begin
			comparisons = comparisons + 1;
			if (seen !== exp) begin
				fails = fails + 1;
				$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
			end
		end
	endtask
	task xfer(input w, input [7:0] a, input [7:0] v);
		begin
			hsel <= 1'b1;
			htrans <= 2'h2;
			hwrite <= w;
			haddr <= {24'h0, a};
			do @(posedge mclk); while (hreadyout !== 1'b1);
			hsel <= 1'b0;
			htrans <= 2'h0;
			hwdata <= {24'h0, v};
			do @(posedge mclk); while (hreadyout !== 1'b1);
			d = hrdata;
		end
	endtask
	task rdc(input [7:0] a, input [7:0] e);
		begin
			xfer(1'b0, a, 8'h00);
			check(d, {24'h0, e});
		end
	endtask
	function [2:0] mexp(input [3:0] c);
		case (c[1:0])
			2'b00: mexp = 3'h0;
			2'b10: mexp = 3'h1;
			2'b01: mexp = 3'h2;
			default: mexp = (c[3] ^ c[2]) ? 3'h3 : 3'h4;
		endcase
	endfunction
	task t_regs;
		begin
			check(tx_irq, 1'b1);
			rdc(`UEFC_OFS_SCRATCH, 8'hFF);
			rdc(`UEFC_OFS_FEATURE, 8'h00);
			rdc(`UEFC_OFS_ENH, 8'h00);
			rdc(`UEFC_OFS_TXCOUNT, 8'h00);
			xfer(1'b1, `UEFC_OFS_TXTRIG, 8'h40);
			rdc(`UEFC_OFS_TXTRIG, 8'h00);
			rdc(8'h3C, 8'h00);
			xfer(1'b1, `UEFC_OFS_SCRATCH, 8'h5A);
			rdc(`UEFC_OFS_SCRATCH, 8'h5A);
			xfer(1'b1, `UEFC_OFS_INT_EN, 8'hFF);
			rdc(`UEFC_OFS_INT_EN, 8'h1F);
			xfer(1'b1, `UEFC_OFS_FIFO_CTL, 8'hFF);
			rdc(`UEFC_OFS_FIFO_CTL, 8'hCF);
			xfer(1'b1, `UEFC_OFS_ENH, 8'h10);
			xfer(1'b1, `UEFC_OFS_INT_EN, 8'hFF);
			xfer(1'b1, `UEFC_OFS_ENH, 8'h00);
			xfer(1'b1, `UEFC_OFS_INT_EN, 8'h00);
			rdc(`UEFC_OFS_INT_EN, 8'hE0);
		end
	endtask
	task t_ir;
		begin
			p.ir_rx <= 1'b1;
			repeat (2) @(posedge mclk);
			check(ir_rx_data, 1'b1);
			xfer(1'b1, `UEFC_OFS_FEATURE, 8'h10);
			repeat (2) @(posedge mclk);
			check(ir_rx_data, 1'b0);
			xfer(1'b1, `UEFC_OFS_FEATURE, 8'h00);
		end
	endtask
	task t_txdis;
		begin
			xfer(1'b1, `UEFC_OFS_ENH, 8'h10);
			xfer(1'b1, `UEFC_OFS_MODEM_WR, 8'h08);
			for (i = 0; i < 3; i = i + 1)
				xfer(1'b1, `UEFC_OFS_TXDATA, 8'h41 + i[7:0]);
			xfer(1'b1, `UEFC_OFS_TXTRIG, 8'h04);
			repeat (2) @(posedge mclk);
			check(tx_level_irq, 1'b1);
			xfer(1'b1, `UEFC_OFS_TXTRIG, 8'h03);
			repeat (30) @(posedge mclk);
			check(tx_level_irq, 1'b0);
			check(txd, 1'b1);
			rdc(`UEFC_OFS_TXCOUNT, 8'h03);
			xfer(1'b1, `UEFC_OFS_MODEM_WR, 8'h00);
			for (i = 0; i < 3; i = i + 1) begin
				p.grab(b);
				check(b, 8'h41 + i[7:0]);
			end
			check(tx_irq, 1'b1);
			rdc(`UEFC_OFS_TXCOUNT, 8'h00);
		end
	endtask
	task t_dir(input [3:0] dl);
		integer n;
		begin
			xfer(1'b1, `UEFC_OFS_MODEM_WR, {dl, 4'h0});
			xfer(1'b1, `UEFC_OFS_TXDATA, 8'h66);
			@(negedge txd);
			@(posedge mclk);
			check(rts_n, 1'b1);
			check(tx_irq, 1'b0);
			n = 1;
			while (rts_n === 1'b1 && n < 200) begin
				@(posedge mclk);
				n = n + 1;
			end
			// Allows one to three cycles of output registering
			check(n > (10 + dl) * B && n <= (10 + dl) * B + 3, 1'b1);
		end
	endtask
	task t_cts(input s);
		begin
			p.cts_n <= 1'b1;
			p.dsr_n <= 1'b1;
			xfer(1'b1, `UEFC_OFS_ENH, 8'h90);
			xfer(1'b1, `UEFC_OFS_MODEM_CTL, {5'h0, s, 2'h0});
			xfer(1'b1, `UEFC_OFS_TXDATA, 8'h5A);
			repeat (40) @(posedge mclk);
			check(txd, 1'b1);
			if (s)
				p.dsr_n <= 1'b0;
			else
				p.cts_n <= 1'b0;
			p.grab(b);
			check(b, 8'h5A);
			p.cts_n <= 1'b0;
			p.dsr_n <= 1'b0;
			xfer(1'b1, `UEFC_OFS_ENH, 8'h10);
			xfer(1'b1, `UEFC_OFS_MODEM_CTL, 8'h00);
		end
	endtask
	task t_rx;
		begin
			xfer(1'b1, `UEFC_OFS_ENH, 8'h30);
			p.send(8'h13);
			@(posedge mclk);
			check({rx_store, rx_store_data}, 9'h113);
			xfer(1'b0, `UEFC_OFS_STATUS, 8'h00);
			check(d[4], 1'b1);
			xfer(1'b1, `UEFC_OFS_ENH, 8'h10);
			xfer(1'b1, `UEFC_OFS_ENH, 8'h31);
			p.send(8'h13);
			@(posedge mclk);
			check({rx_store, xoff_seen}, 2'b01);
			xfer(1'b0, `UEFC_OFS_STATUS, 8'h00);
			check(d[4:3], 2'b11);
			p.send(8'h12);
			@(posedge mclk);
			check(xon_seen, 1'b1);
			xfer(1'b1, `UEFC_OFS_ENH, 8'h10);
			xfer(1'b1, `UEFC_OFS_ENH, 8'h13);
			p.send(8'h11);
			@(posedge mclk);
			p.send(8'h13);
			@(posedge mclk);
			check(xoff_seen, 1'b0);
			off1 <= 8'h24;
			p.send(8'h24);
			@(posedge mclk);
			p.send(8'h13);
			@(posedge mclk);
			check(xoff_seen, 1'b1);
		end
	endtask
	task t_modes;
		begin
			for (i = 0; i < 16; i = i + 1) begin
				xfer(1'b1, `UEFC_OFS_ENH, 8'h10);
				xfer(1'b1, `UEFC_OFS_ENH, {4'h1, i[3:0]});
				repeat (2) @(posedge mclk);
				check(tx_flow_sel, i[3:2]);
				check(rx_cmp_mode, mexp(i[3:0]));
			end
			xfer(1'b1, `UEFC_OFS_ENH, 8'h10);
		end
	endtask
	task t_arts;
		begin
			xfer(1'b1, `UEFC_OFS_MODEM_CTL, 8'h03);
			repeat (2) @(posedge mclk);
			check(rts_n, 1'b0);
			check(dtr_n, 1'b0);
			xfer(1'b1, `UEFC_OFS_MODEM_CTL, 8'h00);
			repeat (2) @(posedge mclk);
			check(rts_n, 1'b1);
			check(dtr_n, 1'b1);
			xfer(1'b1, `UEFC_OFS_RXTRIG, 8'h20);
			xfer(1'b1, `UEFC_OFS_ENH, 8'h50);
			xfer(1'b1, `UEFC_OFS_MODEM_CTL, 8'h02);
			for (i = 0; i < 12; i = i + 1) begin
				xfer(1'b1, `UEFC_OFS_FEATURE, ft[i]);
				p.rx_level <= lv[i];
				repeat (3) @(posedge mclk);
				check(rts_n, ex[i]);
				check(rx_trig_irq, lv[i] >= 7'h20);
			end
		end
	endtask
	initial begin
		repeat (2) @(posedge mclk);
		rst <= 1'b0;
		@(posedge mclk);
		t_regs;
		t_ir;
		t_txdis;
		xfer(1'b1, `UEFC_OFS_FEATURE, 8'h20);
		t_dir(4'h0);
		t_dir(4'h3);
		xfer(1'b1, `UEFC_OFS_FEATURE, 8'h00);
		t_cts(1'b0);
		t_cts(1'b1);
		t_rx;
		t_modes;
		t_arts;
		conclude;
	end
endmodule // test_uart_enhanced_feature_control
